/* File: rtl/ecfg_pkg.sv */
// Package of constants for the Ethernet controller configuration bank
package ecfg_pkg;
  // Register indices within a bank (byte address is four times the index)
  localparam logic [3:0] IDX_CHIP_ID = 4'h0;
  localparam logic [3:0] IDX_GLOBAL_LED = 4'ha;
  localparam logic [3:0] IDX_IND_CMD = 4'h0;
  localparam logic [3:0] IDX_IND_RSV_A = 4'h2;
  localparam logic [3:0] IDX_IND_RSV_B = 4'h4;
  localparam logic [3:0] IDX_IND_RSV_C = 4'h6;
  localparam logic [3:0] IDX_IND_LOW = 4'h8;
  localparam logic [3:0] IDX_IND_HIGH = 4'ha;
  localparam logic [3:0] IDX_PHY_CTRL = 4'h0;
  localparam logic [3:0] IDX_BANK_SEL = 4'he;
  // Bank numbers
  localparam logic [5:0] BANK_CHIP = 6'h20;
  localparam logic [5:0] BANK_INDIRECT = 6'h2a;
  localparam logic [5:0] BANK_PHY = 6'h2d;
  // Identification fields, values arbitrary
  localparam logic [7:0] ID_FAMILY = 8'h5a;
  localparam logic [3:0] ID_CHIP = 4'h3;
  localparam logic [2:0] ID_REVISION = 3'h2;
  // Reset values
  localparam logic [15:0] RST_GLOBAL_LED = 16'h0835;
  localparam logic [15:0] RST_PHY_CTRL = 16'h1020;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [5:0] RST_BANK = 6'h00;
  // Global LED control field positions
  localparam int LED_SEL_HI_BIT = 15;
  localparam int LED_SEL_LO_BIT = 9;
  // Indirect command field positions
  localparam int CMD_DIR_BIT = 12;
  localparam int CMD_TBL_HI = 11;
  localparam int CMD_TBL_LO = 10;
  localparam logic [1:0] TBL_STATS = 2'h3;
  // PHY control field positions
  localparam int PHY_SPEED_BIT = 13;
  localparam int PHY_AN_EN_BIT = 12;
  localparam int PHY_PDOWN_BIT = 11;
  localparam int PHY_AN_RST_BIT = 9;
  localparam int PHY_DUPLEX_BIT = 8;
  localparam int PHY_XALG_BIT = 5;
  localparam int PHY_FMDIX_BIT = 4;
  localparam int PHY_NOMDIX_BIT = 3;
  localparam int PHY_TXOFF_BIT = 1;
  localparam int PHY_LEDOFF_BIT = 0;
  // Writable PHY control bits (soft reset, isolate, collision test, bit 6 read zero)
  localparam logic [15:0] PHY_WR_MASK = 16'h7b3f;
  // LED selector codes
  localparam logic [1:0] LED_MODE_A = 2'h0;
  localparam logic [1:0] LED_MODE_B = 2'h1;
  localparam logic [1:0] LED_MODE_C = 2'h2;
endpackage

/* File: rtl/ecfg_bank.sv */
// Configuration register bank of a single-port Ethernet controller on Avalon-MM
//
// Contract
// - Read-only ID: family, chip, revision fields
// - LED selector from global bits 15 and 9
// - Selector picks port LED functions per mode
// - Command write launches access; bit12 gives direction
// - Table field 11 selects statistics counters
// - Ten-bit indirect address in command bits 9-0
// - Low data register holds data bits 15-0
// - High data register holds data bits 31-16
// - Indirect data 0x02-0x06 read zero, read-only
// - PHY bit 12 enables auto-negotiation, resets one
// - Bit 13 forces 100/10 when negotiation off
// - Bit 8 forces duplex when negotiation off/failed
// - Bit 11 powers down the physical layer
// - Writing bit 9 restarts auto-negotiation
// - Bit 5 selects crossover algorithm, resets one
// - Bit 3 disables automatic crossover
// - Bit 1 disables transmitter, bit 0 LEDs
// - Soft reset, isolate, collision test read zero
// - Bank select reachable at 0xE in every bank
`timescale 1ns/1ps
module ecfg_bank
(
  // Clock, reset and clock enable
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Statistics counter access port
  output logic stat_req_out,
  output logic stat_read_out,
  output logic [9:0] stat_addr_out,
  output logic [31:0] stat_wdata_out,
  input wire logic stat_ack_in,
  input wire logic [31:0] stat_rdata_in,
  // Link state from the physical layer
  input wire logic link_up_in,
  input wire logic activity_in,
  input wire logic collision_in,
  input wire logic an_speed_100_in,
  input wire logic an_full_duplex_in,
  input wire logic an_failed_in,
  // Physical layer controls
  output logic speed_100_out,
  output logic full_duplex_out,
  output logic an_enable_out,
  output logic an_restart_out,
  output logic power_down_out,
  output logic xover_algo_out,
  output logic force_mdix_out,
  output logic mdix_disable_out,
  output logic tx_disable_out,
  // Port LEDs, high is lit
  output logic [3:0] port_led_out
);

  // Bus handshake states
  typedef enum logic {ECFG_IDLE, ECFG_ANSWER} ecfg_bus_t;

  // Merge a write under byte enables into a 16-bit register
  function automatic logic [15:0] ecfg_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [15:0] res;
    res = old_v;
    if (be[0])
      res[7:0] = wd[7:0];
    if (be[1])
      res[15:8] = wd[15:8];
    return res;
  endfunction

  // True when the access hits a register of the given bank and index
  function automatic logic ecfg_hit(input logic [5:0] cur, input logic [5:0] bank, input logic [3:0] idx,
                                    input logic [3:0] want);
    return (cur == bank) && (idx == want);
  endfunction

  // Reset synchroniser
  logic rst_meta_r; // First stage, read only by second
  logic rst_n_r; // Released reset for the design
  // Registers
  ecfg_bus_t bus_r; // Handshake state
  logic [5:0] bank_r; // Current bank
  logic [15:0] led_ctl_r; // Global LED control
  logic [15:0] cmd_r; // Indirect command
  logic [15:0] data_lo_r; // Indirect data bits 15-0
  logic [15:0] data_hi_r; // Indirect data bits 31-16
  logic [15:0] phy_r; // PHY basic control
  logic rd_pend_r; // Indirect read awaiting its answer
  logic [1:0] led_sel; // Two-bit LED selector
  logic [3:0] idx; // Register index of the access
  logic commit; // Write takes effect this edge
  logic [15:0] rd_nxt; // Read mux result
  logic [15:0] cmd_nxt; // Indirect command after the byte-enable merge
  default clocking ecfg_cb @(posedge core_clk_in); endclocking // Checks sample on the core clock
  default disable iff (!rst_n_r); // Checks rest while the design is in reset

  assign idx = avs_address_in[5:2];
  assign commit = ce_in && avs_write_in && (bus_r == ECFG_ANSWER);
  assign cmd_nxt = ecfg_merge(cmd_r, avs_writedata_in, avs_byteenable_in);
  assign led_sel = {led_ctl_r[ecfg_pkg::LED_SEL_HI_BIT], led_ctl_r[ecfg_pkg::LED_SEL_LO_BIT]};

  // Reset release through two flops
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Read mux over the selected bank
  always_comb
  begin
    rd_nxt = ecfg_pkg::RST_ZERO;
    if (idx == ecfg_pkg::IDX_BANK_SEL)
      rd_nxt = {10'h000, bank_r};
    else if (ecfg_hit(bank_r, ecfg_pkg::BANK_CHIP, idx, ecfg_pkg::IDX_CHIP_ID))
      rd_nxt = {ecfg_pkg::ID_FAMILY, ecfg_pkg::ID_CHIP, ecfg_pkg::ID_REVISION, 1'b0};
    else if (ecfg_hit(bank_r, ecfg_pkg::BANK_CHIP, idx, ecfg_pkg::IDX_GLOBAL_LED))
      rd_nxt = led_ctl_r;
    else if (ecfg_hit(bank_r, ecfg_pkg::BANK_INDIRECT, idx, ecfg_pkg::IDX_IND_CMD))
      rd_nxt = cmd_r;
    else if (ecfg_hit(bank_r, ecfg_pkg::BANK_INDIRECT, idx, ecfg_pkg::IDX_IND_LOW))
      rd_nxt = data_lo_r;
    else if (ecfg_hit(bank_r, ecfg_pkg::BANK_INDIRECT, idx, ecfg_pkg::IDX_IND_HIGH))
      rd_nxt = data_hi_r;
    else if (ecfg_hit(bank_r, ecfg_pkg::BANK_PHY, idx, ecfg_pkg::IDX_PHY_CTRL))
      rd_nxt = phy_r & ecfg_pkg::PHY_WR_MASK;
    // Reserved data words and everything else read zero
  end

  // Avalon handshake: one wait cycle, then the answer
  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      bus_r <= ECFG_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      case (bus_r)
        ECFG_IDLE:
        begin
          // Request seen: load read data and drop waitrequest
          if (avs_read_in || avs_write_in)
          begin
            bus_r <= ECFG_ANSWER;
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= {16'h0000, rd_nxt};
          end
        end
        ECFG_ANSWER:
        begin
          // Master samples the answer at this edge
          bus_r <= ECFG_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
        default:
        begin
          bus_r <= ECFG_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // Bank select, writable in any bank
  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      bank_r <= ecfg_pkg::RST_BANK;
    else if (commit && idx == ecfg_pkg::IDX_BANK_SEL && avs_byteenable_in[0])
      bank_r <= avs_writedata_in[5:0];
  end

  // Global LED control, all bits writable
  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      led_ctl_r <= ecfg_pkg::RST_GLOBAL_LED;
    else if (commit && ecfg_hit(bank_r, ecfg_pkg::BANK_CHIP, idx, ecfg_pkg::IDX_GLOBAL_LED))
      led_ctl_r <= ecfg_merge(led_ctl_r, avs_writedata_in, avs_byteenable_in);
  end

  // Indirect command register and access launch
  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cmd_r <= ecfg_pkg::RST_ZERO;
      stat_req_out <= 1'b0;
      stat_read_out <= 1'b0;
      stat_addr_out <= 10'h000;
      stat_wdata_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      stat_req_out <= 1'b0;
      if (commit && ecfg_hit(bank_r, ecfg_pkg::BANK_INDIRECT, idx, ecfg_pkg::IDX_IND_CMD))
      begin
        cmd_r <= cmd_nxt;
        // Only the statistics table is served; other codes store but launch nothing
        if (cmd_nxt[ecfg_pkg::CMD_TBL_HI:ecfg_pkg::CMD_TBL_LO] == ecfg_pkg::TBL_STATS)
        begin
          stat_req_out <= 1'b1;
          stat_read_out <= cmd_nxt[ecfg_pkg::CMD_DIR_BIT];
          stat_addr_out <= cmd_nxt[9:0];
          stat_wdata_out <= {data_hi_r, data_lo_r};
        end
      end
    end
  end

  // Indirect read pending until the counter store answers
  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rd_pend_r <= 1'b0;
    else if (ce_in)
    begin
      if (stat_req_out && stat_read_out)
        rd_pend_r <= 1'b1;
      else if (stat_ack_in)
        rd_pend_r <= 1'b0;
    end
  end

  // Indirect data words; a counter answer wins over a host write
  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      data_lo_r <= ecfg_pkg::RST_ZERO;
      data_hi_r <= ecfg_pkg::RST_ZERO;
    end
    else if (ce_in)
    begin
      if (rd_pend_r && stat_ack_in)
      begin
        data_lo_r <= stat_rdata_in[15:0];
        data_hi_r <= stat_rdata_in[31:16];
      end
      else if (commit && ecfg_hit(bank_r, ecfg_pkg::BANK_INDIRECT, idx, ecfg_pkg::IDX_IND_LOW))
        data_lo_r <= ecfg_merge(data_lo_r, avs_writedata_in, avs_byteenable_in);
      else if (commit && ecfg_hit(bank_r, ecfg_pkg::BANK_INDIRECT, idx, ecfg_pkg::IDX_IND_HIGH))
        data_hi_r <= ecfg_merge(data_hi_r, avs_writedata_in, avs_byteenable_in);
    end
  end

  // PHY basic control; unsupported bits stay zero, restart bit self-clears
  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      phy_r <= ecfg_pkg::RST_PHY_CTRL;
    else if (ce_in)
    begin
      if (commit && ecfg_hit(bank_r, ecfg_pkg::BANK_PHY, idx, ecfg_pkg::IDX_PHY_CTRL))
        phy_r <= ecfg_merge(phy_r, avs_writedata_in, avs_byteenable_in) & ecfg_pkg::PHY_WR_MASK;
      else
        phy_r[ecfg_pkg::PHY_AN_RST_BIT] <= 1'b0;
    end
  end

  // Physical layer control outputs
  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      an_enable_out <= 1'b1;
      speed_100_out <= 1'b0;
      full_duplex_out <= 1'b0;
      an_restart_out <= 1'b0;
      power_down_out <= 1'b0;
      xover_algo_out <= 1'b1;
      force_mdix_out <= 1'b0;
      mdix_disable_out <= 1'b0;
      tx_disable_out <= 1'b0;
    end
    else if (ce_in)
    begin
      an_enable_out <= phy_r[ecfg_pkg::PHY_AN_EN_BIT];
      // Forced speed only when negotiation is off
      speed_100_out <= phy_r[ecfg_pkg::PHY_AN_EN_BIT] ? an_speed_100_in : phy_r[ecfg_pkg::PHY_SPEED_BIT];
      // Forced duplex when negotiation is off or has failed
      full_duplex_out <= (!phy_r[ecfg_pkg::PHY_AN_EN_BIT] || an_failed_in) ? phy_r[ecfg_pkg::PHY_DUPLEX_BIT]
                         : an_full_duplex_in;
      an_restart_out <= phy_r[ecfg_pkg::PHY_AN_RST_BIT];
      power_down_out <= phy_r[ecfg_pkg::PHY_PDOWN_BIT];
      xover_algo_out <= phy_r[ecfg_pkg::PHY_XALG_BIT];
      force_mdix_out <= phy_r[ecfg_pkg::PHY_FMDIX_BIT];
      mdix_disable_out <= phy_r[ecfg_pkg::PHY_NOMDIX_BIT];
      tx_disable_out <= phy_r[ecfg_pkg::PHY_TXOFF_BIT];
    end
  end

  // Port LED functions; link/activity lit on link, dark while active
  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      port_led_out <= 4'h0;
    else if (ce_in)
    begin
      if (phy_r[ecfg_pkg::PHY_LEDOFF_BIT])
        port_led_out <= 4'h0;
      else
      begin
        case (led_sel)
          ecfg_pkg::LED_MODE_A:
            port_led_out <= {1'b0, link_up_in && !activity_in, full_duplex_out || collision_in,
                             speed_100_out};
          ecfg_pkg::LED_MODE_B:
            port_led_out <= {1'b0, link_up_in && speed_100_out && !activity_in,
                             link_up_in && !speed_100_out && !activity_in, full_duplex_out};
          ecfg_pkg::LED_MODE_C:
            port_led_out <= {activity_in, link_up_in, full_duplex_out || collision_in, speed_100_out};
          default:
            port_led_out <= 4'h0; // Undefined selector leaves LEDs dark
        endcase
      end
    end
  end

  // Checks
  property p_chip_id;
    (!avs_waitrequest_out && avs_read_in && bank_r == ecfg_pkg::BANK_CHIP && idx == ecfg_pkg::IDX_CHIP_ID)
      |-> avs_readdata_out == {16'h0000, ecfg_pkg::ID_FAMILY, ecfg_pkg::ID_CHIP, ecfg_pkg::ID_REVISION, 1'b0};
  endproperty
  a_chip_id: assert property (p_chip_id) else $error("identification word wrong");
  property p_led_mode_c;
    (ce_in && led_sel == ecfg_pkg::LED_MODE_C && !phy_r[ecfg_pkg::PHY_LEDOFF_BIT])
      |=> port_led_out[3:2] == {$past(activity_in), $past(link_up_in)};
  endproperty
  a_led_mode_c: assert property (p_led_mode_c) else $error("activity or link LED wrong");
  property p_launch;
    (commit && bank_r == ecfg_pkg::BANK_INDIRECT && idx == ecfg_pkg::IDX_IND_CMD
     && avs_byteenable_in == 4'hf && avs_writedata_in[11:10] == ecfg_pkg::TBL_STATS)
      |=> stat_req_out && stat_read_out == $past(avs_writedata_in[12]) ##1 !stat_req_out || !$past(ce_in);
  endproperty
  a_launch: assert property (p_launch) else $error("indirect access not launched");
  property p_table;
    stat_req_out |-> cmd_r[11:10] == ecfg_pkg::TBL_STATS;
  endproperty
  a_table: assert property (p_table) else $error("launch on reserved table");
  property p_addr;
    stat_req_out |-> stat_addr_out == cmd_r[9:0];
  endproperty
  a_addr: assert property (p_addr) else $error("indirect address mismatch");
  property p_data_load;
    (ce_in && rd_pend_r && stat_ack_in) |=> {data_hi_r, data_lo_r} == $past(stat_rdata_in);
  endproperty
  a_data_load: assert property (p_data_load) else $error("counter data not captured");
  property p_reserved_zero;
    (!avs_waitrequest_out && avs_read_in && bank_r == ecfg_pkg::BANK_INDIRECT
     && (idx == ecfg_pkg::IDX_IND_RSV_A || idx == ecfg_pkg::IDX_IND_RSV_B || idx == ecfg_pkg::IDX_IND_RSV_C))
      |-> avs_readdata_out == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved data word not zero");
  property p_speed;
    (ce_in && !phy_r[ecfg_pkg::PHY_AN_EN_BIT]) |=> speed_100_out == $past(phy_r[ecfg_pkg::PHY_SPEED_BIT]);
  endproperty
  a_speed: assert property (p_speed) else $error("forced speed not applied");
  property p_duplex;
    (ce_in && phy_r[ecfg_pkg::PHY_AN_EN_BIT] && an_failed_in)
      |=> full_duplex_out == $past(phy_r[ecfg_pkg::PHY_DUPLEX_BIT]);
  endproperty
  a_duplex: assert property (p_duplex) else $error("forced duplex after failed negotiation");
  property p_restart;
    $rose(an_restart_out) |=> !phy_r[ecfg_pkg::PHY_AN_RST_BIT] || !$past(ce_in);
  endproperty
  a_restart: assert property (p_restart) else $error("restart bit did not clear");
  property p_unsupported;
    phy_r[15] == 1'b0 && phy_r[10] == 1'b0 && phy_r[7] == 1'b0;
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("unsupported PHY bit set");

  // Main scenarios
  c_ind_read: cover property (rd_pend_r && stat_ack_in);
  c_forced: cover property (!an_enable_out && speed_100_out);
  c_mode_b: cover property (led_sel == ecfg_pkg::LED_MODE_B);

endmodule

/* File: tb/ecfg_stat_model.sv */
// Statistics counter store model facing the indirect access port
`timescale 1ns/1ps
module ecfg_stat_model
#(
  parameter int DLY = 5 // Answer delay in cycles
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Access port
  input wire logic req_in,
  input wire logic read_in,
  input wire logic [9:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic ack_out,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [16]; // Small counter array, low address bits only
  logic pend_r; // Read waiting for answer
  int cnt_r; // Cycles left before answer
  // Stores writes, answers reads late; a counter ticks once after a write
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ack_out <= 1'b0;
      rdata_out <= 32'h0;
      pend_r <= 1'b0;
      cnt_r <= 0;
    end
    else
    begin
      ack_out <= 1'b0;
      // Data is not valid outside the answer cycle
      rdata_out <= ~rdata_out;
      if (req_in && !read_in)
        mem[addr_in[3:0]] <= wdata_in;
      if (req_in && read_in)
      begin
        pend_r <= 1'b1;
        cnt_r <= DLY;
      end
      else if (pend_r && cnt_r == 0)
      begin
        ack_out <= 1'b1;
        rdata_out <= mem[addr_in[3:0]] + 32'h1;
        pend_r <= 1'b0;
      end
      else if (pend_r)
        cnt_r <= cnt_r - 1;
    end
  end
endmodule

/* File: tb/ecfg_bank_tb.sv */
// Self-checking testbench of the configuration register bank
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, s); end end
module ecfg_bank_tb;
  typedef struct {logic [5:0] bk; logic [5:0] a; logic w; logic [15:0] d; logic [15:0] e;} ecfg_row_t;
  logic core_clk_in = 0, nrst_in = 0, ce_in = 1, avs_read_in = 0, avs_write_in = 0;
  logic [5:0] avs_address_in = 6'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, stat_wdata_out, stat_rdata_in;
  logic [3:0] avs_byteenable_in = 4'hf, port_led_out;
  logic avs_waitrequest_out, stat_req_out, stat_read_out, stat_ack_in;
  logic [9:0] stat_addr_out;
  logic link_up_in = 0, activity_in = 0, collision_in = 0;
  logic an_speed_100_in = 0, an_full_duplex_in = 0, an_failed_in = 0;
  logic speed_100_out, full_duplex_out, an_enable_out, an_restart_out, power_down_out;
  logic xover_algo_out, force_mdix_out, mdix_disable_out, tx_disable_out;
  logic [7:0] ctl; // Physical layer controls gathered
  logic [15:0] q; // Last read value
  logic [31:0] lw; // Last launched write data
  logic [9:0] la; // Last launched address
  logic lr; // Last launched direction
  int num_errors = 0, checks = 0, n_req = 0, n_rst = 0, n_ack = 0, n0;
  ecfg_row_t rows [13] = '{
    '{6'h20, 6'h00, 1, 16'hffff, 16'h5a34}, '{6'h20, 6'h28, 0, 16'h0, 16'h0835},
    '{6'h20, 6'h30, 1, 16'hffff, 16'h0}, '{6'h2a, 6'h00, 0, 16'h0, 16'h0},
    '{6'h2a, 6'h08, 1, 16'hffff, 16'h0}, '{6'h2a, 6'h10, 1, 16'hffff, 16'h0},
    '{6'h2a, 6'h18, 1, 16'hffff, 16'h0}, '{6'h2a, 6'h20, 1, 16'h1234, 16'h1234},
    '{6'h2a, 6'h28, 1, 16'habcd, 16'habcd}, '{6'h2a, 6'h38, 0, 16'h0, 16'h002a},
    '{6'h2d, 6'h00, 0, 16'h0, 16'h1020}, '{6'h2d, 6'h00, 1, 16'hffff, 16'h793f},
    '{6'h2d, 6'h38, 0, 16'h0, 16'h002d}};
  logic [15:0] led_ctl [4] = '{16'h0835, 16'h0a35, 16'h8835, 16'h8a35}; // Selector 00..11
  logic [3:0] led_exp [4] = '{4'h3, 4'h1, 4'hf, 4'h0}; // Lit LEDs with link, activity, 100, full
  assign ctl = {speed_100_out, full_duplex_out, an_enable_out, power_down_out,
                xover_algo_out, force_mdix_out, mdix_disable_out, tx_disable_out};
  // Clock at 25 MHz
  always #20 core_clk_in = ~core_clk_in;
  // Design under test
  ecfg_bank dut_u (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .stat_req_out(stat_req_out), .stat_read_out(stat_read_out), .stat_addr_out(stat_addr_out),
    .stat_wdata_out(stat_wdata_out), .stat_ack_in(stat_ack_in), .stat_rdata_in(stat_rdata_in),
    .link_up_in(link_up_in), .activity_in(activity_in), .collision_in(collision_in),
    .an_speed_100_in(an_speed_100_in), .an_full_duplex_in(an_full_duplex_in), .an_failed_in(an_failed_in),
    .speed_100_out(speed_100_out), .full_duplex_out(full_duplex_out), .an_enable_out(an_enable_out),
    .an_restart_out(an_restart_out), .power_down_out(power_down_out), .xover_algo_out(xover_algo_out),
    .force_mdix_out(force_mdix_out), .mdix_disable_out(mdix_disable_out),
    .tx_disable_out(tx_disable_out), .port_led_out(port_led_out));
  // Counter store on the far side
  ecfg_stat_model stat_u (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .req_in(stat_req_out),
    .read_in(stat_read_out), .addr_in(stat_addr_out), .wdata_in(stat_wdata_out),
    .ack_out(stat_ack_in), .rdata_out(stat_rdata_in));
  // Records launches, restart pulses and answers at mid-cycle, where they are settled
  always @(negedge core_clk_in)
  begin
    if (stat_req_out === 1'b1)
    begin
      n_req++;
      lr = stat_read_out;
      la = stat_addr_out;
      lw = stat_wdata_out;
    end
    if (an_restart_out === 1'b1) n_rst++;
    if (stat_ack_in === 1'b1) n_ack++;
  end
  // One bus cycle, held until waitrequest is seen low; two idle edges let outputs and counts settle
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    avs_address_in <= a;
    avs_writedata_in <= {16'h0, d};
    avs_read_in <= !w;
    avs_write_in <= w;
    do begin @(posedge core_clk_in); end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out[15:0];
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask
  // Prints counts and verdict, ends the run
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge core_clk_in);
    num_errors++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge core_clk_in);
    `CHK("rst_ctl", 8'h28, ctl)
    nrst_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    foreach (rows[i])
    begin
      bus(1, 6'h38, {10'h0, rows[i].bk});
      if (rows[i].w) bus(1, rows[i].a, rows[i].d);
      bus(0, rows[i].a, 16'h0);
      `CHK("row", rows[i].e, q)
    end
    $display("done registers");
    bus(1, 6'h38, 16'h002a);
    n0 = n_req;
    bus(1, 6'h00, 16'h0c07);
    `CHK("wr_launch", {n0 + 1, 1'b0, 10'h007, 32'habcd1234}, {n_req, lr, la, lw})
    bus(1, 6'h00, 16'h1c07);
    `CHK("rd_launch", {n0 + 2, 1'b1}, {n_req, lr})
    while (n_ack == 0) @(posedge core_clk_in);
    bus(0, 6'h20, 16'h0);
    `CHK("rd_low", 16'h1235, q)
    bus(0, 6'h28, 16'h0);
    `CHK("rd_high", 16'habcd, q)
    n0 = n_req;
    bus(1, 6'h00, 16'h1807);
    repeat (3) @(posedge core_clk_in);
    `CHK("no_launch", n0, n_req)
    $display("done indirect");
    bus(1, 6'h38, 16'h002d);
    bus(1, 6'h00, 16'h2100);
    `CHK("forced", 8'hc0, ctl)
    an_speed_100_in <= 1'b1;
    an_full_duplex_in <= 1'b1;
    bus(1, 6'h00, 16'h1000);
    `CHK("negotiated", 8'he0, ctl)
    an_failed_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    `CHK("an_failed", 8'ha0, ctl)
    n0 = n_rst;
    bus(1, 6'h00, 16'h0a1b);
    `CHK("ctl_set", 8'h17, ctl)
    `CHK("restart", n0 + 1, n_rst)
    `CHK("led_off", 4'h0, port_led_out)
    bus(1, 6'h00, 16'h0020);
    `CHK("ctl_clr", 8'h08, ctl)
    $display("done phy");
    bus(1, 6'h00, 16'h2100);
    link_up_in <= 1'b1;
    activity_in <= 1'b1;
    bus(1, 6'h38, 16'h0020);
    foreach (led_ctl[i])
    begin
      bus(1, 6'h28, led_ctl[i]);
      @(posedge core_clk_in);
      `CHK("leds", led_exp[i], port_led_out)
    end
    $display("done leds");
    nrst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    `CHK("rst_mid", 8'h28, ctl)
    nrst_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    bus(0, 6'h38, 16'h0);
    `CHK("rst_bank", 16'h0000, q)
    bus(1, 6'h38, 16'h002d);
    bus(0, 6'h00, 16'h0);
    `CHK("rst_phy", 16'h1020, q)
    $display("done reset");
    stop_test();
  end
endmodule
